// >>> src/fspsc_ctrl.sv
// Flash self-program section control: section split, locks, READ_WHILE_WRITE_REGION handling
`timescale 1ns/100ps
`default_nettype none
`include "fspsc_regs.svh"

module fspsc_ctrl
	import fspsc_pkg::*;
#(
	parameter int ADDR_W     = 13,
	parameter int FUSE_W     = 2,
	parameter int PAGE_W     = 6,
	parameter logic [ADDR_W-1:0] NO_READ_WHILE_WRITE_REGION_START = 13'h1800
) (
	// Clock and reset
	input  wire logic              core_clk,
	input  wire logic              rst,
	// Fuses and external programming
	input  wire logic [FUSE_W-1:0] boot_size_fuses,
	input  wire logic              chip_erase,
	input  wire logic              ext_lock_wr,
	input  wire logic [3:0]        ext_lock_data,
	// CPU store request
	input  wire logic              store_program_memory_instr,
	input  wire logic              store_is_lock_write,
	input  wire logic [ADDR_W-1:0] fetch_addr,
	input  wire logic [ADDR_W-1:0] z_addr,
	input  wire logic [3:0]        store_lock_data,
	// Flash array engine
	output logic                   flash_start,
	output logic [ADDR_W-PAGE_W-1:0] flash_page,
	input  wire logic              flash_done,
	// CPU control
	output logic                   cpu_halt,
	output logic                   rww_read_block,
	// Read protection check
	input  wire logic              lpm_req,
	input  wire logic [ADDR_W-1:0] lpm_addr,
	output logic                   lpm_denied,
	// Register bus
	input  wire logic [3:0]        reg_addr,
	input  wire logic [7:0]        reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic [7:0]             reg_rdata,
	// Interrupt
	output logic                   irq
);

	// ----------------------------------------------------------------
	// Section decode
	// ----------------------------------------------------------------
	logic [ADDR_W-1:0] boot_start;
	logic [ADDR_W-1:0] boot_words;

	// Boot part grows down from the top in steps set by fuses
	always_comb begin
		boot_words = ADDR_W'(`FSPSC_BOOT_MIN_WORDS) << (~boot_size_fuses);
		boot_start = ADDR_W'(ADDR_W'(0) - boot_words);
		if (boot_start < NO_READ_WHILE_WRITE_REGION_START) begin
			boot_start = NO_READ_WHILE_WRITE_REGION_START;
		end
	end

	function automatic logic in_boot(input logic [ADDR_W-1:0] a,
	                                 input logic [ADDR_W-1:0] bs);
		in_boot = (a >= bs);
	endfunction : in_boot

	function automatic fspsc_prot_t lock_decode(input logic [1:0] pair);
		fspsc_prot_t p;
		p = '0;
		case (pair)
			`FSPSC_LOCK_FREE: p = '0;
			`FSPSC_LOCK_NOWR: p.write_blocked = 1'b1;
			`FSPSC_LOCK_ALL:  p = '{write_blocked: 1'b1, read_blocked: 1'b1};
			`FSPSC_LOCK_NORD: p.read_blocked = 1'b1;
			default:          p = '0;
		endcase
		lock_decode = p;
	endfunction : lock_decode

	// ----------------------------------------------------------------
	// Lock bits: [1:0] application pair, [3:2] boot pair
	// ----------------------------------------------------------------
	logic [3:0]  lock_ff;
	fspsc_prot_t app_prot;
	fspsc_prot_t boot_prot;

	// Writes can only program bits (1 to 0); erase restores all ones
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			lock_ff <= `FSPSC_LOCK_RESET;
		end else if (chip_erase) begin
			lock_ff <= `FSPSC_LOCK_ERASED;
		end else if (ext_lock_wr) begin
			lock_ff <= lock_ff & ext_lock_data;
		end else if (store_program_memory_instr && store_is_lock_write
		             && in_boot(fetch_addr, boot_start)) begin
			lock_ff <= lock_ff & store_lock_data;
		end
	end

	assign app_prot  = lock_decode(lock_ff[1:0]);
	assign boot_prot = lock_decode(lock_ff[3:2]);

	// Cross-region table reads, plain fetches unaffected by pages
	always_comb begin
		lpm_denied = 1'b0;
		if (lpm_req) begin
			if (in_boot(fetch_addr, boot_start) && !in_boot(lpm_addr, boot_start)) begin
				lpm_denied = app_prot.read_blocked;
			end else if (!in_boot(fetch_addr, boot_start) && in_boot(lpm_addr, boot_start)) begin
				lpm_denied = boot_prot.read_blocked;
			end
		end
	end

	// ----------------------------------------------------------------
	// Programming sequence
	// ----------------------------------------------------------------
	fspsc_state_t state_ff;
	logic         tgt_no_read_while_write_region_ff;
	logic         busy_ff;
	logic         req;
	logic         accept;
	logic         tgt_locked;
	logic         tgt_no_read_while_write_region;
	logic         busy_clr;

	assign req        = store_program_memory_instr && !store_is_lock_write;
	assign tgt_no_read_while_write_region   = (z_addr >= NO_READ_WHILE_WRITE_REGION_START);
	assign tgt_locked = in_boot(z_addr, boot_start) ? boot_prot.write_blocked
	                                                : app_prot.write_blocked;
	// Only boot-part code starts anything; target may be any page
	assign accept = req && (state_ff == FSPSC_IDLE) && in_boot(fetch_addr, boot_start)
	                && !tgt_locked;
	assign busy_clr = reg_wr && (reg_addr == `FSPSC_ADDR_CTRL)
	                  && reg_wdata[`FSPSC_CTRL_BUSY_CLR];

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_ff <= FSPSC_IDLE;
		end else begin
			case (state_ff)
				FSPSC_IDLE: if (accept) state_ff <= FSPSC_PROG;
				FSPSC_PROG: if (flash_done) state_ff <= FSPSC_DONE;
				FSPSC_DONE: state_ff <= FSPSC_IDLE;
				default:    state_ff <= FSPSC_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			tgt_no_read_while_write_region_ff <= 1'b0;
			flash_page  <= '0;
		end else if (accept) begin
			tgt_no_read_while_write_region_ff <= tgt_no_read_while_write_region;
			flash_page  <= z_addr[ADDR_W-1:PAGE_W];
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			flash_start <= 1'b0;
		end else begin
			flash_start <= accept;
		end
	end

	// Busy: set on READ_WHILE_WRITE_REGION start, held until software clears after done
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			busy_ff <= 1'b0;
		end else if (accept && !tgt_no_read_while_write_region) begin
			busy_ff <= 1'b1;
		end else if (busy_clr && state_ff == FSPSC_IDLE) begin
			busy_ff <= 1'b0;
		end
	end

	// Halt only for NO_READ_WHILE_WRITE_REGION targets; READ_WHILE_WRITE_REGION targets keep CPU running
	assign cpu_halt       = (state_ff == FSPSC_PROG) && tgt_no_read_while_write_region_ff;
	assign rww_read_block = busy_ff || cpu_halt;

	// ----------------------------------------------------------------
	// Interrupts
	// ----------------------------------------------------------------
	logic [`FSPSC_IRQ_W-1:0] irq_stat_ff;
	logic [`FSPSC_IRQ_W-1:0] irq_mask_ff;
	logic [`FSPSC_IRQ_W-1:0] irq_evt;

	assign irq_evt[`FSPSC_IRQ_DONE]   = (state_ff == FSPSC_DONE);
	assign irq_evt[`FSPSC_IRQ_REJECT] = req && !accept;

	// Set wins over write-one-to-clear
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			irq_stat_ff <= '0;
		end else if (reg_wr && reg_addr == `FSPSC_ADDR_IRQ_STAT) begin
			irq_stat_ff <= (irq_stat_ff & ~reg_wdata[`FSPSC_IRQ_W-1:0]) | irq_evt;
		end else begin
			irq_stat_ff <= irq_stat_ff | irq_evt;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			irq_mask_ff <= '0;
		end else if (reg_wr && reg_addr == `FSPSC_ADDR_IRQ_MASK) begin
			irq_mask_ff <= reg_wdata[`FSPSC_IRQ_W-1:0];
		end
	end

	assign irq = |(irq_stat_ff & irq_mask_ff);

	// ----------------------------------------------------------------
	// Register read
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			case (reg_addr)
				`FSPSC_ADDR_STATUS:   reg_rdata <= {5'h00, (state_ff != FSPSC_IDLE),
				                                    cpu_halt, rww_read_block};
				`FSPSC_ADDR_LOCK:     reg_rdata <= {4'h0, lock_ff};
				`FSPSC_ADDR_IRQ_STAT: reg_rdata <= {6'h00, irq_stat_ff};
				`FSPSC_ADDR_IRQ_MASK: reg_rdata <= {6'h00, irq_mask_ff};
				`FSPSC_ADDR_FUSE:     reg_rdata <= 8'(boot_size_fuses);
				default:              reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_app_store_ignored: assert property (@(posedge core_clk) disable iff (rst)
		(req && !in_boot(fetch_addr, boot_start)) |=> !flash_start)
		else $error("store from application part started programming");

	a_start_from_boot: assert property (@(posedge core_clk) disable iff (rst)
		flash_start |-> $past(in_boot(fetch_addr, boot_start)))
		else $error("programming started outside boot part");

	a_boot_in_no_read_while_write_region: assert property (@(posedge core_clk) disable iff (rst)
		boot_start >= NO_READ_WHILE_WRITE_REGION_START)
		else $error("boot part reaches into READ_WHILE_WRITE_REGION region");

	a_rww_no_halt: assert property (@(posedge core_clk) disable iff (rst)
		(state_ff == FSPSC_PROG && !tgt_no_read_while_write_region_ff) |-> (!cpu_halt && busy_ff))
		else $error("CPU halted for READ_WHILE_WRITE_REGION target");

	a_no_read_while_write_region_halts: assert property (@(posedge core_clk) disable iff (rst)
		(flash_start && tgt_no_read_while_write_region_ff) |-> cpu_halt)
		else $error("CPU not halted for NO_READ_WHILE_WRITE_REGION target");

	a_busy_reads_one: assert property (@(posedge core_clk) disable iff (rst)
		(reg_rd && reg_addr == `FSPSC_ADDR_STATUS && busy_ff) |=> reg_rdata[`FSPSC_ST_BUSY])
		else $error("busy bit not read as one");

	a_busy_set_start: assert property (@(posedge core_clk) disable iff (rst)
		(accept && !tgt_no_read_while_write_region) |=> busy_ff [*2])
		else $error("busy bit not set at READ_WHILE_WRITE_REGION start");

	a_lock_only_prog: assert property (@(posedge core_clk) disable iff (rst)
		(!chip_erase) |=> ((lock_ff & ~$past(lock_ff)) == 4'h0))
		else $error("lock bit unprogrammed without chip erase");

	a_locked_write: assert property (@(posedge core_clk) disable iff (rst)
		(req && in_boot(z_addr, boot_start) && lock_ff[3:2] == `FSPSC_LOCK_NOWR)
		|=> !flash_start)
		else $error("write to locked boot part started");

	a_boot_store_any: assert property (@(posedge core_clk) disable iff (rst)
		(req && state_ff == FSPSC_IDLE && in_boot(fetch_addr, boot_start)
		 && lock_ff == `FSPSC_LOCK_ERASED) |=> flash_start)
		else $error("free store from boot part not started");

	a_app_write_lock: assert property (@(posedge core_clk) disable iff (rst)
		(req && !in_boot(z_addr, boot_start) && !lock_ff[0]) |=> !flash_start)
		else $error("write to write-locked application part started");

	a_boot_write_lock: assert property (@(posedge core_clk) disable iff (rst)
		(req && in_boot(z_addr, boot_start) && !lock_ff[2]) |=> !flash_start)
		else $error("write to write-locked boot part started");

	a_app_read_lock: assert property (@(posedge core_clk) disable iff (rst)
		(lpm_req && in_boot(fetch_addr, boot_start) && !in_boot(lpm_addr, boot_start))
		|-> (lpm_denied == !lock_ff[1]))
		else $error("application read lock not applied");

	a_boot_read_lock: assert property (@(posedge core_clk) disable iff (rst)
		(lpm_req && !in_boot(fetch_addr, boot_start) && in_boot(lpm_addr, boot_start))
		|-> (lpm_denied == !lock_ff[3]))
		else $error("boot read lock not applied");

	a_same_part_read: assert property (@(posedge core_clk) disable iff (rst)
		(lpm_req && (in_boot(fetch_addr, boot_start) == in_boot(lpm_addr, boot_start)))
		|-> !lpm_denied)
		else $error("read inside one part was denied");

	a_page_from_z: assert property (@(posedge core_clk) disable iff (rst)
		flash_start |-> (flash_page == $past(z_addr[ADDR_W-1:PAGE_W])))
		else $error("page not taken from target address");

	a_region_from_z: assert property (@(posedge core_clk) disable iff (rst)
		flash_start |-> (tgt_no_read_while_write_region_ff == $past(z_addr >= NO_READ_WHILE_WRITE_REGION_START)))
		else $error("region not taken from target address");

	a_halt_whole_op: assert property (@(posedge core_clk) disable iff (rst)
		(state_ff == FSPSC_PROG && tgt_no_read_while_write_region_ff && !flash_done) |=> cpu_halt)
		else $error("CPU released before NO_READ_WHILE_WRITE_REGION operation ended");

	a_busy_held_prog: assert property (@(posedge core_clk) disable iff (rst)
		(busy_ff && state_ff != FSPSC_IDLE) |=> busy_ff)
		else $error("busy bit dropped while programming");

	a_erase_unlocks: assert property (@(posedge core_clk) disable iff (rst)
		chip_erase |=> (lock_ff == `FSPSC_LOCK_ERASED))
		else $error("chip erase did not unprogram lock bits");

	a_busy_clr_idle: assert property (@(posedge core_clk) disable iff (rst)
		(busy_clr && state_ff == FSPSC_IDLE && !accept) |=> !busy_ff)
		else $error("busy bit not cleared by software");

endmodule : fspsc_ctrl
`default_nettype wire

// >>> src/fspsc_regs.svh
// Constants for the flash self-program section control block
`ifndef FSPSC_REGS_SVH
`define FSPSC_REGS_SVH

// ----------------------------------------------------------------
// Register bus offsets
// ----------------------------------------------------------------
`define FSPSC_ADDR_CTRL     4'h0
`define FSPSC_ADDR_STATUS   4'h1
`define FSPSC_ADDR_LOCK     4'h2
`define FSPSC_ADDR_IRQ_STAT 4'h3
`define FSPSC_ADDR_IRQ_MASK 4'h4
`define FSPSC_ADDR_FUSE     4'h5

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define FSPSC_CTRL_BUSY_CLR 0
`define FSPSC_ST_BUSY       0
`define FSPSC_ST_HALT       1
`define FSPSC_ST_ACTIVE     2
`define FSPSC_IRQ_DONE      0
`define FSPSC_IRQ_REJECT    1
`define FSPSC_IRQ_W         2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define FSPSC_LOCK_RESET    4'hF
`define FSPSC_LOCK_ERASED   4'hF

// ----------------------------------------------------------------
// Boot part size
// ----------------------------------------------------------------
`define FSPSC_BOOT_MIN_WORDS 13'h0100

// ----------------------------------------------------------------
// Lock pair codes, 0 is programmed
// ----------------------------------------------------------------
`define FSPSC_LOCK_FREE     2'h3
`define FSPSC_LOCK_NOWR     2'h2
`define FSPSC_LOCK_ALL      2'h0
`define FSPSC_LOCK_NORD     2'h1

`endif

// >>> src/fspsc_pkg.sv
// Types for the flash self-program section control block
package fspsc_pkg;

	typedef enum logic [2:0] {
		FSPSC_IDLE = 3'h1,
		FSPSC_PROG = 3'h2,
		FSPSC_DONE = 3'h4
	} fspsc_state_t;

	typedef struct packed {
		logic write_blocked;
		logic read_blocked;
	} fspsc_prot_t;

endpackage : fspsc_pkg

// >>> verification/fspsc_flash_model.sv
// Flash array engine model answering start pulses after a set delay
`timescale 1ns/100ps
`default_nettype none

module fspsc_flash_model (
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       rst,
	// Engine handshake
	input  wire logic       flash_start,
	input  wire logic [7:0] op_cycles,
	output logic            flash_done
);
	logic [7:0] cnt_ff;
	logic       run_ff;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cnt_ff     <= 8'h00;
			run_ff     <= 1'b0;
			flash_done <= 1'b0;
		end else begin
			flash_done <= run_ff && (cnt_ff == 8'h00);
			if (flash_start) begin
				run_ff <= 1'b1;
				cnt_ff <= op_cycles;
			end else if (run_ff && (cnt_ff == 8'h00)) begin
				run_ff <= 1'b0;
			end else if (run_ff) begin
				cnt_ff <= cnt_ff - 8'h01;
			end
		end
	end
endmodule : fspsc_flash_model

`default_nettype wire

// >>> verification/flash_self_program_section_control_bench.sv
// Self-checking bench for the flash self-program section control
`timescale 1ns/100ps
`default_nettype none
`include "fspsc_regs.svh"

module flash_self_program_section_control_bench;
	typedef struct packed {
		logic [1:0] f; logic [12:0] fa; logic [12:0] z; logic st; logic hl; logic bz;
	} fspsc_row_t;
	// Fuses, fetch place, target, expected start, halt, busy
	fspsc_row_t rows [5] = '{'{2'h3, 13'h1F00, 13'h1900, 1'b1, 1'b1, 1'b0},
		'{2'h3, 13'h1E00, 13'h0100, 1'b0, 1'b0, 1'b0},
		'{2'h2, 13'h1E00, 13'h0100, 1'b1, 1'b0, 1'b1},
		'{2'h0, 13'h1800, 13'h1FC0, 1'b1, 1'b1, 1'b0},
		'{2'h3, 13'h1FFF, 13'h0000, 1'b1, 1'b0, 1'b1}};
	logic core_clk = 0, rst = 1, chip_erase = 0, ext_lock_wr = 0, lpm_req = 0;
	logic store_program_memory_instr = 0, store_is_lock_write = 0, reg_wr = 0, reg_rd = 0;
	logic [1:0] boot_size_fuses = 2'h3;
	logic [3:0] ext_lock_data = 4'hF, store_lock_data = 4'hF, reg_addr = 4'h0;
	logic [12:0] fetch_addr = 13'h0000, z_addr = 13'h0000, lpm_addr = 13'h0000;
	logic [7:0] reg_wdata = 8'h00, op_cycles = 8'h00, rd;
	logic [6:0] flash_page;
	logic flash_start, flash_done, cpu_halt, rww_read_block, lpm_denied, irq;
	logic [7:0] reg_rdata;
	int num_errors = 0, n_checks = 0, k;

	always #10 core_clk = ~core_clk;

	fspsc_ctrl i_fspsc_ctrl (.core_clk(core_clk), .rst(rst), .boot_size_fuses(boot_size_fuses),
		.chip_erase(chip_erase), .ext_lock_wr(ext_lock_wr), .ext_lock_data(ext_lock_data),
		.store_program_memory_instr(store_program_memory_instr),
		.store_is_lock_write(store_is_lock_write), .fetch_addr(fetch_addr), .z_addr(z_addr),
		.store_lock_data(store_lock_data), .flash_start(flash_start), .flash_page(flash_page),
		.flash_done(flash_done), .cpu_halt(cpu_halt), .rww_read_block(rww_read_block),
		.lpm_req(lpm_req), .lpm_addr(lpm_addr), .lpm_denied(lpm_denied), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
	fspsc_flash_model i_fspsc_flash_model (.core_clk(core_clk), .rst(rst),
		.flash_start(flash_start), .op_cycles(op_cycles), .flash_done(flash_done));

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge core_clk);
		reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		#1;
	endtask : wr

	task rdr(input logic [3:0] a);
		@(posedge core_clk);
		reg_addr <= a; reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 rd = reg_rdata;
	endtask : rdr

	task store(input logic [1:0] f, input logic lw, input logic [12:0] fa, input logic [12:0] z,
		input logic [3:0] ld);
		@(posedge core_clk);
		boot_size_fuses <= f; store_is_lock_write <= lw; fetch_addr <= fa;
		z_addr <= z; store_lock_data <= ld; store_program_memory_instr <= 1'b1;
		@(posedge core_clk);
		store_program_memory_instr <= 1'b0;
		#1;
	endtask : store

	task close_out;
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : close_out

	initial begin
		#200000;
		num_errors++;
		close_out();
	end

	initial begin
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		rdr(`FSPSC_ADDR_STATUS); chk(rd, 8'h00);
		rdr(`FSPSC_ADDR_LOCK); chk(rd, 8'h0F);
		rdr(4'hF); chk(rd, 8'h00);
		chk(irq, 1'b0);
		$display("reset test done");
		// ----------------------------------------------------------------
		// Store table
		// ----------------------------------------------------------------
		foreach (rows[i]) begin
			op_cycles <= i[0] ? 8'h0C : 8'h00;
			store(rows[i].f, 1'b0, rows[i].fa, rows[i].z, 4'hF);
			chk(flash_start, rows[i].st);
			chk(cpu_halt, rows[i].hl);
			if (rows[i].st) chk(flash_page, rows[i].z[12:6]);
			for (k = 0; k < 40 && rows[i].st && flash_done !== 1'b1; k++) @(posedge core_clk) #1;
			chk(cpu_halt, rows[i].hl);
			@(posedge core_clk) #1 chk(cpu_halt, 1'b0);
			rdr(`FSPSC_ADDR_STATUS); chk(rd[0], rows[i].bz);
			chk(rww_read_block, rows[i].bz);
			wr(`FSPSC_ADDR_CTRL, 8'h01);
			rdr(`FSPSC_ADDR_STATUS); chk(rd, 8'h00);
			$display("row %0d done", i);
		end
		// ----------------------------------------------------------------
		// Store and busy clear while programming
		// ----------------------------------------------------------------
		op_cycles <= 8'h0C;
		store(2'h3, 1'b0, 13'h1F00, 13'h0040, 4'hF);
		rdr(`FSPSC_ADDR_STATUS); chk(rd, 8'h05);
		wr(`FSPSC_ADDR_CTRL, 8'h01);
		store(2'h3, 1'b0, 13'h1F00, 13'h0040, 4'hF);
		chk(flash_start, 1'b0);
		rdr(`FSPSC_ADDR_STATUS); chk(rd, 8'h05);
		for (k = 0; k < 40 && flash_done !== 1'b1; k++) @(posedge core_clk) #1;
		repeat (2) @(posedge core_clk);
		wr(`FSPSC_ADDR_CTRL, 8'h01);
		rdr(`FSPSC_ADDR_STATUS); chk(rd, 8'h00);
		$display("busy test done");
		// ----------------------------------------------------------------
		// Interrupt, locks and table reads
		// ----------------------------------------------------------------
		wr(`FSPSC_ADDR_IRQ_MASK, 8'h02);
		chk(irq, 1'b1);
		wr(`FSPSC_ADDR_IRQ_STAT, 8'h03);
		rdr(`FSPSC_ADDR_IRQ_STAT); chk(rd, 8'h00);
		chk(irq, 1'b0);
		store(2'h3, 1'b1, 13'h1F00, 13'h0000, 4'hA);
		rdr(`FSPSC_ADDR_LOCK); chk(rd, 8'h0A);
		store(2'h3, 1'b0, 13'h1F00, 13'h0100, 4'hF);
		chk(flash_start, 1'b0);
		store(2'h3, 1'b0, 13'h1F00, 13'h1F80, 4'hF);
		chk(flash_start, 1'b0);
		@(posedge core_clk) #1 chk(irq, 1'b1);
		@(posedge core_clk) chip_erase <= 1'b1;
		@(posedge core_clk) chip_erase <= 1'b0;
		rdr(`FSPSC_ADDR_LOCK); chk(rd, 8'h0F);
		@(posedge core_clk) begin
			ext_lock_wr <= 1'b1; ext_lock_data <= 4'h3;
		end
		@(posedge core_clk) ext_lock_wr <= 1'b0;
		rdr(`FSPSC_ADDR_LOCK); chk(rd, 8'h03);
		store(2'h3, 1'b0, 13'h1F00, 13'h1F40, 4'hF);
		chk(flash_start, 1'b0);
		@(posedge core_clk) begin
			lpm_req <= 1'b1; fetch_addr <= 13'h0100; lpm_addr <= 13'h1F00;
		end
		#1 chk(lpm_denied, 1'b1);
		@(posedge core_clk) lpm_addr <= 13'h0200;
		#1 chk(lpm_denied, 1'b0);
		@(posedge core_clk) fetch_addr <= 13'h1F00;
		#1 chk(lpm_denied, 1'b0);
		@(posedge core_clk) lpm_req <= 1'b0;
		$display("lock test done");
		close_out();
	end
endmodule : flash_self_program_section_control_bench

`default_nettype wire
